/* smc_pkg.sv */
// Constants and types shared by the operating mode controller files.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
`default_nettype none
package smc_pkg;
	typedef enum logic [2:0] {
		SMC_OFF, SMC_STANDBY, SMC_NORMAL, SMC_SLEEP,
		SMC_OVERLOAD, SMC_RESET, SMC_FSP, SMC_FNORMAL
	} smc_mode_t;

	localparam logic [2:0] MODE_SEL_SLEEP = 3'h1;
	localparam logic [2:0] MODE_SEL_STANDBY = 3'h4;
	localparam logic [2:0] MODE_SEL_NORMAL = 3'h7;
	localparam logic [4:0] CAUSE_ILLEGAL_SLEEP = 5'h14;
	localparam logic [4:0] CAUSE_NONE = 5'h00;
	localparam logic [4:0] CAUSE_EXT_RESET = 5'h01;
	localparam logic [4:0] CAUSE_POWER_ON = 5'h02;
	localparam logic [1:0] RESET_COUNT_LIMIT = 2'h3;

	localparam logic [6:0] OFS_MAIN_STATE = 7'h03;
	localparam logic [6:0] OFS_WDOG_STATE = 7'h05;
	localparam logic [6:0] OFS_NV_CFG_A = 7'h70;
	localparam logic [6:0] OFS_NV_CFG_B = 7'h75;
	localparam logic [6:0] OFS_ID_A = 7'h7e;
	localparam logic [6:0] OFS_ID_B = 7'h7f;

	localparam int CLK_MHZ = 250;
	localparam int ACT_DELAY_NS = 100;
	localparam int ACT_DELAY_CYC = (ACT_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_HOLD_NS = 20000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int OV_DET_NS = 1000;
	localparam int OV_DET_CYC = (OV_DET_NS * CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

/* smc_delay.sv */
// Counts a run of cycles while its start level stays high, then flags done.
// Assumes start comes from logic on the same clock.
`default_nettype none
module smc_delay #(
	parameter int CYCLES = 4
) (
	input wire logic mclk, // Clock.
	input wire logic rst, // Synchronous reset.
	input wire logic run, // Count while high, clear when low.
	output logic done // High once the count has elapsed.
);
	logic [15:0] cnt_reg;
	wire logic at_end = (cnt_reg >= 16'(CYCLES));

	always_ff @(posedge mclk) begin
		if (rst || !run)
			cnt_reg <= 16'h0000;
		else if (!at_end)
			cnt_reg <= cnt_reg + 16'h0001;
	end
	assign done = run && at_end;
endmodule
`default_nettype wire

/* smc_reg_guard.sv */
// Decides which register accesses the serial port may perform per mode.
// Assumes the serial front end presents a decoded register index.
`default_nettype none
module smc_reg_guard
	import smc_pkg::*;
(
	input wire smc_pkg::smc_mode_t mode, // Current operating mode.
	input wire logic [6:0] addr, // Register index of the access.
	input wire logic factory_preset, // Non-volatile area still untouched.
	output logic rd_ok, // Read is permitted.
	output logic nv_wr_ok // Non-volatile write is permitted.
);
	function automatic logic is_limited(input logic [6:0] a);
		return a == OFS_MAIN_STATE || a == OFS_WDOG_STATE || a == OFS_ID_A
			|| a == OFS_ID_B || a == OFS_NV_CFG_A || a == OFS_NV_CFG_B;
	endfunction

	wire logic spi_live = (mode == SMC_STANDBY) || (mode == SMC_NORMAL);
	wire logic is_nv = (addr == OFS_NV_CFG_A) || (addr == OFS_NV_CFG_B);
	assign rd_ok = spi_live || (mode == SMC_FNORMAL && is_limited(addr));
	assign nv_wr_ok = is_nv && factory_preset && (spi_live || mode == SMC_FNORMAL);
endmodule
`default_nettype wire

/* smc_core.sv */
// Operating mode state machine of the supply controller.
// Assumes detector flags and the reset pin are asynchronous; commands are synchronous.
// Behaviour
// - Start in Off; on power-on detection run a system reset, then Standby.
// - Fall to Off from any mode when supplies drop below power-off.
// - In Off all regulators are off and buses are high impedance.
// - Overload, Sleep wake, Normal reset pass through Reset only when count below three.
// - Normal goes to Standby on mode select value 100.
// - Standby goes to Normal on mode select value 111.
// - Value 001 enters Sleep only with nothing pending and a wake source enabled.
// - A refused sleep command triggers a system reset with cause 10100.
// - With sleep disabled, sleep commands are ignored entirely.
// - Counter overflow in Reset goes to preparation, clears count, then Sleep or Reset.
// - Preparation restores defaults, clears interrupts, enables sources, sets limp home.
// - Sleep is left to Reset only on a regular or diagnostic wake-up.
// - Overtemperature or lasting overvoltage forces Overload from any mode but Off.
// - Overload turns off supplies, holds reset low, sets limp home, floats buses.
// - Overload ends when cool and not overvoltage, or at power-off; reset follows.
// - Reset holds the reset pin low, then moves to Standby once released.
// - In Normal, transceivers, battery monitor and low-side drivers start after an activation delay.
// - Forced Normal powers transceivers and supplies, disables I/Os and watchdog.
// - Forced Normal limits reads to a few registers; reprogramming only when factory fresh.
// - Forced Normal follows power-on when selected; external resets are then ignored.
// - Forced Normal ends on reprogramming, Overload or Off, with a system reset.
// - Standby or Normal enter Overload on overvoltage or overtemperature.
`default_nettype none
module smc_core
	import smc_pkg::*;
(
	input wire logic mclk, // 250 MHz clock.
	input wire logic rst, // Synchronous reset, power-on.
	input wire logic pon_det, // Battery above power-on threshold.
	input wire logic poff_det, // Battery and converter below power-off threshold.
	input wire logic otp_act, // Temperature above activation threshold.
	input wire logic otp_rel, // Temperature below release threshold.
	input wire logic bat_ov, // Battery above overvoltage threshold.
	input wire logic mode_wr, // Pulse: mode select field written.
	input wire logic [2:0] mode_select_field, // Requested mode value.
	input wire logic reset_event, // Pulse: external reset source fired.
	input wire logic reset_pin_n_in, // Level seen on the reset pin.
	input wire logic wake_event, // Pulse: regular or diagnostic wake-up.
	input wire logic irq_pending, // Interrupt or wake-up still pending.
	input wire logic wake_src_en, // At least one regular wake source enabled.
	input wire logic sleep_disable_bit, // Non-volatile sleep disable.
	input wire logic forced_normal_bit, // Non-volatile forced normal select.
	input wire logic nv_programmed, // Pulse: non-volatile area written.
	input wire logic factory_preset, // Non-volatile area in factory state.
	input wire logic [6:0] reg_addr, // Register index of a serial access.
	output logic reg_rd_ok, // Serial read permitted.
	output logic reg_nv_wr_ok, // Non-volatile write permitted.
	output logic reset_pin_n_out, // Reset pin drive value, low only.
	output logic reset_pin_n_oe, // Reset pin driven.
	output logic limp_home_bit, // Limp home active.
	output logic [1:0] reset_count_field, // Reset counter.
	output logic [4:0] reset_cause_field, // Last reset cause.
	output logic mcu_supply_regulator, // Microcontroller regulator enable.
	output logic aux_regulator, // Auxiliary regulator enable.
	output logic switching_converter, // Converter enable.
	output logic bus_enable, // Transceivers out of high impedance.
	output logic bus_active, // Transceivers and battery monitor active.
	output logic high_voltage_io_enable, // High-voltage I/O enabled.
	output logic high_voltage_io_ls_enable, // High-voltage I/O low-side drivers enabled.
	output logic high_voltage_io_failsafe, // High-voltage I/O in fail-safe.
	output logic watchdog_enable, // Watchdog enabled.
	output logic spi_enable, // Serial port accepts accesses.
	output logic defaults_load, // Pulse: restore control defaults.
	output logic irq_clear_all, // Pulse: clear all pending interrupts.
	output logic irq_enable_all, // Pulse: enable all regular sources.
	output smc_pkg::smc_mode_t mode // Current operating mode.
);
	// Two-stage synchronisers for the asynchronous detector and pin levels.
	logic [5:0] sync1_reg, sync2_reg;
	always_ff @(posedge mclk) begin
		sync1_reg <= {pon_det, poff_det, otp_act, otp_rel, bat_ov, reset_pin_n_in};
		sync2_reg <= sync1_reg;
	end
	wire logic pon_s = sync2_reg[5];
	wire logic poff_s = sync2_reg[4];
	wire logic otp_act_s = sync2_reg[3];
	wire logic otp_rel_s = sync2_reg[2];
	wire logic ov_s = sync2_reg[1];
	wire logic pin_high_s = sync2_reg[0];

	smc_mode_t mode_reg, mode_next;
	logic fn_lock_reg, fn_lock_next; // Forced normal selected at power-on.
	logic [1:0] cnt_reg, cnt_next;
	logic [4:0] cause_reg, cause_next;
	logic lhc_reg, lhc_next;
	logic fsp_pulse_reg;

	// Overvoltage only counts once it has persisted the detection time.
	wire logic ov_long;
	smc_delay #(.CYCLES(OV_DET_CYC)) u_ov (
		.mclk(mclk),
		.rst(rst),
		.run(ov_s),
		.done(ov_long)
	);

	// Reset pin is held low for a minimum period on each Reset entry.
	wire logic rst_hold_done;
	smc_delay #(.CYCLES(RST_HOLD_CYC)) u_hold (
		.mclk(mclk),
		.rst(rst),
		.run(mode_reg == SMC_RESET),
		.done(rst_hold_done)
	);

	// Delayed activation of the Normal mode functions.
	wire logic act_done;
	smc_delay #(.CYCLES(ACT_DELAY_CYC)) u_act (
		.mclk(mclk),
		.rst(rst),
		.run(mode_reg == SMC_NORMAL),
		.done(act_done)
	);

	smc_reg_guard u_guard (
		.mode(mode_reg),
		.addr(reg_addr),
		.factory_preset(factory_preset),
		.rd_ok(reg_rd_ok),
		.nv_wr_ok(reg_nv_wr_ok)
	);

	wire logic cmd_sleep = mode_wr && mode_select_field == MODE_SEL_SLEEP
		&& !sleep_disable_bit;
	wire logic sleep_ok = !irq_pending && wake_src_en;
	wire logic cmd_normal = mode_wr && mode_select_field == MODE_SEL_NORMAL;
	wire logic cmd_standby = mode_wr && mode_select_field == MODE_SEL_STANDBY;
	wire logic overload_trip = otp_act_s || ov_long;
	wire logic overload_clear = otp_rel_s && !ov_s;
	wire logic cnt_ovf = (cnt_reg >= RESET_COUNT_LIMIT);
	wire logic rst_ev_live = reset_event && !fn_lock_reg;

	// Entering Reset from Standby, Normal, Sleep or Overload bumps the counter; an overflow is handled inside Reset.
	always_comb begin
		mode_next = mode_reg;
		cnt_next = cnt_reg;
		cause_next = cause_reg;
		lhc_next = lhc_reg;
		fn_lock_next = fn_lock_reg;
		if (mode_reg != SMC_OFF && poff_s) begin
			mode_next = SMC_OFF;
			fn_lock_next = 1'b0;
		end else if (mode_reg != SMC_OFF && mode_reg != SMC_OVERLOAD && overload_trip) begin
			mode_next = SMC_OVERLOAD;
			fn_lock_next = 1'b0;
		end else begin
			case (mode_reg)
				SMC_OFF: begin
					if (pon_s) begin
						cause_next = CAUSE_POWER_ON;
						if (forced_normal_bit) begin
							mode_next = SMC_FNORMAL;
							fn_lock_next = 1'b1;
						end else begin
							mode_next = SMC_RESET;
						end
					end
				end
				SMC_STANDBY, SMC_NORMAL: begin
					if (rst_ev_live) begin
						mode_next = SMC_RESET;
						cause_next = CAUSE_EXT_RESET;
						cnt_next = cnt_reg + 2'h1;
					end else if (cmd_sleep && sleep_ok) begin
						mode_next = SMC_SLEEP;
					end else if (cmd_sleep) begin
						mode_next = SMC_RESET;
						cause_next = CAUSE_ILLEGAL_SLEEP;
						cnt_next = cnt_reg + 2'h1;
					end else if (cmd_normal && mode_reg == SMC_STANDBY) begin
						mode_next = SMC_NORMAL;
					end else if (cmd_standby && mode_reg == SMC_NORMAL) begin
						mode_next = SMC_STANDBY;
					end // Other values fall through as no-ops.
				end
				SMC_SLEEP: begin
					if (wake_event) begin
						mode_next = SMC_RESET;
						cnt_next = cnt_reg + 2'h1;
					end
				end
				SMC_OVERLOAD: begin
					if (overload_clear) begin
						mode_next = SMC_RESET;
						cnt_next = cnt_reg + 2'h1;
					end
				end
				SMC_RESET: begin
					if (cnt_ovf) begin
						mode_next = SMC_FSP;
						cnt_next = 2'h0;
					end else if (rst_hold_done && pin_high_s) begin
						mode_next = SMC_STANDBY;
					end
				end
				SMC_FSP: begin
					lhc_next = 1'b1;
					mode_next = sleep_disable_bit ? SMC_RESET : SMC_SLEEP;
				end
				SMC_FNORMAL: begin
					if (nv_programmed) begin
						mode_next = SMC_RESET;
						fn_lock_next = 1'b0;
					end
				end
				default: mode_next = SMC_OFF;
			endcase
		end
		// Limp home is raised on the entry edge, so the pin is already low throughout FORCED_SLEEP_PREPARATION.
		if (mode_next == SMC_OVERLOAD || mode_next == SMC_FSP)
			lhc_next = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_reg <= SMC_OFF;
			cnt_reg <= 2'h0;
			cause_reg <= CAUSE_NONE;
			lhc_reg <= 1'b0;
			fn_lock_reg <= 1'b0;
			fsp_pulse_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			cnt_reg <= cnt_next;
			cause_reg <= cause_next;
			lhc_reg <= lhc_next;
			fn_lock_reg <= fn_lock_next;
			fsp_pulse_reg <= (mode_next == SMC_FSP) && (mode_reg != SMC_FSP);
		end
	end

	// Per-mode enables; Off and Overload keep every enable low, and Overload raises the fail-safe.
	wire logic m_on = mode_reg != SMC_OFF && mode_reg != SMC_OVERLOAD;
	wire logic m_fn = mode_reg == SMC_FNORMAL;
	assign mcu_supply_regulator = m_on && mode_reg != SMC_SLEEP;
	assign aux_regulator = m_on;
	assign switching_converter = m_on;
	assign bus_enable = m_on;
	assign bus_active = m_fn || act_done;
	assign high_voltage_io_enable = m_on && !m_fn;
	assign high_voltage_io_ls_enable = act_done;
	assign high_voltage_io_failsafe = mode_reg == SMC_OVERLOAD;
	assign watchdog_enable = m_on && !m_fn;
	assign spi_enable = mode_reg == SMC_STANDBY || mode_reg == SMC_NORMAL || m_fn;
	// The pin is open-drain: it is only ever pulled low.
	assign reset_pin_n_out = 1'b0;
	assign reset_pin_n_oe = !(mode_reg == SMC_STANDBY || mode_reg == SMC_NORMAL
		|| m_fn || (mode_reg == SMC_RESET && rst_hold_done));
	assign limp_home_bit = lhc_reg;
	assign reset_count_field = cnt_reg;
	assign reset_cause_field = cause_reg;
	assign defaults_load = fsp_pulse_reg;
	assign irq_clear_all = fsp_pulse_reg;
	assign irq_enable_all = fsp_pulse_reg;
	assign mode = mode_reg;

	// Assertions.
	property p_off_on_poff;
		@(posedge mclk) disable iff (rst) poff_s |=> mode_reg == SMC_OFF;
	endproperty
	a_off_on_poff: assert property (p_off_on_poff) else $error("no Off on power loss");

	property p_off_quiet;
		@(posedge mclk) disable iff (rst)
			mode_reg == SMC_OFF |-> !mcu_supply_regulator && !aux_regulator && !bus_enable;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("Off mode not quiet");

	property p_normal_to_standby;
		@(posedge mclk) disable iff (rst)
			mode_reg == SMC_NORMAL && cmd_standby && !poff_s && !overload_trip && !rst_ev_live
			|=> mode_reg == SMC_STANDBY;
	endproperty
	a_normal_to_standby: assert property (p_normal_to_standby) else $error("no Standby");

	property p_standby_to_normal;
		@(posedge mclk) disable iff (rst)
			mode_reg == SMC_STANDBY && cmd_normal && !poff_s && !overload_trip && !rst_ev_live
			|=> mode_reg == SMC_NORMAL;
	endproperty
	a_standby_to_normal: assert property (p_standby_to_normal) else $error("no Normal");

	property p_bad_sleep;
		@(posedge mclk) disable iff (rst)
			(mode_reg == SMC_NORMAL || mode_reg == SMC_STANDBY) && cmd_sleep && !sleep_ok
			&& !poff_s && !overload_trip && !rst_ev_live
			|=> mode_reg == SMC_RESET && reset_cause_field == CAUSE_ILLEGAL_SLEEP;
	endproperty
	a_bad_sleep: assert property (p_bad_sleep) else $error("bad sleep not reset");

	property p_sleep_disabled;
		@(posedge mclk) disable iff (rst)
			(mode_reg == SMC_NORMAL || mode_reg == SMC_STANDBY) && mode_wr && sleep_disable_bit
			&& mode_select_field == MODE_SEL_SLEEP && !poff_s && !overload_trip
			&& !rst_ev_live |=> mode_reg == $past(mode_reg);
	endproperty
	a_sleep_disabled: assert property (p_sleep_disabled) else $error("sleep not ignored");

	sequence s_fsp_enter;
		mode_reg == SMC_RESET && cnt_ovf && !poff_s && !overload_trip;
	endsequence
	sequence s_fsp_exit;
		mode_reg == SMC_FSP && cnt_reg == 2'h0 ##1 limp_home_bit;
	endsequence
	property p_fsp;
		@(posedge mclk) disable iff (rst) s_fsp_enter |=> s_fsp_exit;
	endproperty
	a_fsp: assert property (p_fsp) else $error("forced sleep path wrong");

	property p_fsp_pulses;
		@(posedge mclk) disable iff (rst)
			$rose(mode_reg == SMC_FSP) |-> defaults_load && irq_clear_all && irq_enable_all;
	endproperty
	a_fsp_pulses: assert property (p_fsp_pulses) else $error("no restore pulses");

	property p_overload_state;
		@(posedge mclk) disable iff (rst)
			mode_reg == SMC_OVERLOAD |-> reset_pin_n_oe && limp_home_bit && !switching_converter;
	endproperty
	a_overload_state: assert property (p_overload_state) else $error("Overload outputs");

	property p_act_delay;
		@(posedge mclk) disable iff (rst)
			$rose(mode_reg == SMC_NORMAL) |-> !bus_active [*2];
	endproperty
	a_act_delay: assert property (p_act_delay) else $error("activation too early");

	property p_sleep_hold;
		@(posedge mclk) disable iff (rst)
			mode_reg == SMC_SLEEP && !wake_event && !poff_s && !overload_trip
			|=> mode_reg == SMC_SLEEP;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("Sleep left without wake");

	property p_fn_no_reset;
		@(posedge mclk) disable iff (rst)
			mode_reg == SMC_FNORMAL && !nv_programmed && !poff_s && !overload_trip
			|=> mode_reg == SMC_FNORMAL;
	endproperty
	a_fn_no_reset: assert property (p_fn_no_reset) else $error("Forced Normal left");

	property p_overload_exit;
		@(posedge mclk) disable iff (rst)
			mode_reg == SMC_OVERLOAD && overload_clear && !poff_s
			|=> mode_reg == SMC_RESET;
	endproperty
	a_overload_exit: assert property (p_overload_exit) else $error("Overload not left");
endmodule
`default_nettype wire

/* smc_mcu_model.sv */
// Microcontroller model on the far side of the reset line and the mode select writes.
// Assumes one clock shared with the controller and a pull-up on the reset pin.
`default_nettype none
module smc_mcu_model (
	input wire logic mclk, // Clock.
	input wire logic reset_pin_n_out, // Controller drive value.
	input wire logic reset_pin_n_oe, // Controller drives the pin.
	input wire logic hold_low, // Firmware keeps the pin low.
	output logic reset_pin_n_in, // Resolved pin level.
	output logic mode_wr, // Pulse: mode written.
	output logic [2:0] mode_select_field // Written mode value.
);
	timeunit 1ns;
	timeprecision 100ps;
	// The pin is open drain with a pull-up, so it reads high unless a party pulls it low.
	assign reset_pin_n_in = ((reset_pin_n_oe && !reset_pin_n_out) || hold_low) ? 1'b0 : 1'b1;
	initial begin
		mode_wr = 1'b0;
		mode_select_field = 3'h0;
	end
	// The field is inverted after the write so that a stale value is never relied upon.
	task automatic send_mode(input logic [2:0] val);
		@(posedge mclk);
		#1;
		mode_wr = 1'b1;
		mode_select_field = val;
		@(posedge mclk);
		#1;
		mode_wr = 1'b0;
		mode_select_field = ~val;
	endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the operating mode controller.
// Assumes smc_pkg, smc_core and smc_mcu_model are compiled before it.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import smc_pkg::*;
	logic mclk, rst, pon_det, poff_det, otp_act, otp_rel, bat_ov, reset_event, wake_event;
	logic irq_pending, wake_src_en, sleep_disable_bit, forced_normal_bit, nv_programmed;
	logic factory_preset, hold_low;
	logic [6:0] reg_addr;
	logic mode_wr, reset_pin_n_in;
	logic [2:0] mode_select_field;
	logic reg_rd_ok, reg_nv_wr_ok, reset_pin_n_out, reset_pin_n_oe, limp_home_bit;
	logic mcu_supply_regulator, aux_regulator, switching_converter, bus_enable, bus_active;
	logic high_voltage_io_enable, high_voltage_io_ls_enable, high_voltage_io_failsafe, watchdog_enable, spi_enable;
	logic defaults_load, irq_clear_all, irq_enable_all;
	logic [1:0] reset_count_field;
	logic [4:0] reset_cause_field;
	smc_mode_t mode;
	int mismatches, check_count;
	logic [6:0] fn_addr [6] = '{7'h03, 7'h05, 7'h70, 7'h75, 7'h7e, 7'h7f};

	smc_core DUT (.mclk, .rst, .pon_det, .poff_det, .otp_act, .otp_rel, .bat_ov, .mode_wr,
		.mode_select_field, .reset_event, .reset_pin_n_in, .wake_event, .irq_pending,
		.wake_src_en, .sleep_disable_bit, .forced_normal_bit, .nv_programmed, .factory_preset,
		.reg_addr, .reg_rd_ok, .reg_nv_wr_ok, .reset_pin_n_out, .reset_pin_n_oe, .limp_home_bit,
		.reset_count_field, .reset_cause_field, .mcu_supply_regulator, .aux_regulator,
		.switching_converter, .bus_enable, .bus_active, .high_voltage_io_enable, .high_voltage_io_ls_enable,
		.high_voltage_io_failsafe, .watchdog_enable, .spi_enable, .defaults_load, .irq_clear_all,
		.irq_enable_all, .mode);
	smc_mcu_model mcu (.mclk, .reset_pin_n_out, .reset_pin_n_oe, .hold_low, .reset_pin_n_in,
		.mode_wr, .mode_select_field);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic tick(input int n = 1);
		repeat (n) begin
			@(posedge mclk);
			#1;
		end
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// A mode that never arrives ends the run, since later scenarios depend on it.
	task automatic wait_mode(input smc_mode_t m, input int lim);
		int i;
		i = 0;
		while (mode !== m && i < lim) begin
			tick();
			i++;
		end
		chk("mode", m, mode);
		if (mode !== m) begin
			end_of_test();
		end
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask

	task automatic t_power_up();
		chk("mode", SMC_OFF, mode);
		chk("supplies", 8'h00, {mcu_supply_regulator, aux_regulator, switching_converter,
			bus_enable});
		pon_det = 1'b1;
		wait_mode(SMC_RESET, 8);
		chk("cause", CAUSE_POWER_ON, reset_cause_field);
		chk("pin drive", 8'h01, reset_pin_n_oe);
		chk("pin level", 8'h00, reset_pin_n_in);
		hold_low = 1'b1;
		tick(RST_HOLD_CYC + 50);
		chk("mode held", SMC_RESET, mode);
		hold_low = 1'b0;
		wait_mode(SMC_STANDBY, 8);
		chk("pin drive", 8'h00, reset_pin_n_oe);
	endtask

	task automatic t_commands();
		for (int v = 0; v < 7; v++) begin
			if (v != 1) begin
				mcu.send_mode(v[2:0]);
				chk("mode", SMC_STANDBY, mode);
			end
		end
		mcu.send_mode(MODE_SEL_NORMAL);
		chk("mode", SMC_NORMAL, mode);
		tick(ACT_DELAY_CYC - 3);
		chk("bus active early", 8'h00, {bus_active, high_voltage_io_ls_enable});
		tick(6);
		chk("bus active", 8'h07, {bus_active, high_voltage_io_ls_enable, spi_enable});
		mcu.send_mode(MODE_SEL_NORMAL);
		chk("mode", SMC_NORMAL, mode);
		mcu.send_mode(MODE_SEL_STANDBY);
		chk("mode", SMC_STANDBY, mode);
	endtask

	task automatic t_sleep_refused();
		irq_pending = 1'b1;
		mcu.send_mode(MODE_SEL_SLEEP);
		wait_mode(SMC_RESET, 4);
		chk("cause", 8'h14, reset_cause_field);
		chk("count", 8'h01, reset_count_field);
		irq_pending = 1'b0;
		wait_mode(SMC_STANDBY, RST_HOLD_CYC + 20);
		sleep_disable_bit = 1'b1;
		mcu.send_mode(MODE_SEL_SLEEP);
		tick(3);
		chk("mode", SMC_STANDBY, mode);
		chk("cause kept", 8'h14, reset_cause_field);
		sleep_disable_bit = 1'b0;
	endtask

	task automatic t_sleep_wake();
		mcu.send_mode(MODE_SEL_NORMAL);
		mcu.send_mode(MODE_SEL_SLEEP);
		wait_mode(SMC_SLEEP, 4);
		chk("mcu supply", 8'h00, {mcu_supply_regulator, spi_enable});
		mcu.send_mode(MODE_SEL_NORMAL);
		tick(3);
		chk("mode", SMC_SLEEP, mode);
		pulse(wake_event);
		wait_mode(SMC_RESET, 4);
		chk("count", 8'h02, reset_count_field);
		wait_mode(SMC_STANDBY, RST_HOLD_CYC + 20);
	endtask

	task automatic t_forced_sleep();
		mcu.send_mode(MODE_SEL_NORMAL);
		pulse(reset_event);
		wait_mode(SMC_FSP, RST_HOLD_CYC + 20);
		chk("restore pulses", 8'h07, {defaults_load, irq_clear_all, irq_enable_all});
		chk("limp home", 8'h01, limp_home_bit);
		wait_mode(SMC_SLEEP, 4);
		chk("count", 8'h00, reset_count_field);
	endtask

	task automatic t_overload();
		otp_act = 1'b1;
		wait_mode(SMC_OVERLOAD, 6);
		chk("supplies", 8'h00, {mcu_supply_regulator, aux_regulator, switching_converter,
			bus_enable});
		chk("pin limp failsafe", 8'h07, {reset_pin_n_oe, limp_home_bit, high_voltage_io_failsafe});
		otp_act = 1'b0;
		otp_rel = 1'b1;
		wait_mode(SMC_RESET, 6);
		wait_mode(SMC_STANDBY, RST_HOLD_CYC + 20);
		bat_ov = 1'b1;
		tick(OV_DET_CYC - 20);
		chk("mode", SMC_STANDBY, mode);
		wait_mode(SMC_OVERLOAD, 30);
		bat_ov = 1'b0;
		wait_mode(SMC_RESET, 6);
		wait_mode(SMC_STANDBY, RST_HOLD_CYC + 20);
		mcu.send_mode(MODE_SEL_NORMAL);
		poff_det = 1'b1;
		pon_det = 1'b0;
		wait_mode(SMC_OFF, 6);
		chk("supplies", 8'h00, {mcu_supply_regulator, aux_regulator, switching_converter,
			bus_enable});
	endtask

	task automatic t_forced_normal();
		forced_normal_bit = 1'b1;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		poff_det = 1'b0;
		pon_det = 1'b1;
		wait_mode(SMC_FNORMAL, RST_HOLD_CYC + 20);
		chk("enables", 8'h1c, {aux_regulator, switching_converter, bus_enable, high_voltage_io_enable,
			watchdog_enable});
		foreach (fn_addr[i]) begin
			reg_addr = fn_addr[i];
			tick();
			chk("read allowed", 8'h01, reg_rd_ok);
		end
		reg_addr = 7'h04;
		tick();
		chk("read allowed", 8'h00, reg_rd_ok);
		factory_preset = 1'b1;
		reg_addr = 7'h70;
		tick();
		chk("nv write allowed", 8'h01, reg_nv_wr_ok);
		pulse(reset_event);
		tick(3);
		chk("mode", SMC_FNORMAL, mode);
		pulse(nv_programmed);
		wait_mode(SMC_RESET, 4);
	endtask

	initial begin
		{rst, pon_det, poff_det, otp_act, otp_rel, bat_ov, reset_event, wake_event} = 8'h80;
		{irq_pending, sleep_disable_bit, forced_normal_bit, nv_programmed} = 4'h0;
		{factory_preset, hold_low} = 2'h0;
		wake_src_en = 1'b1;
		reg_addr = 7'h00;
		mismatches = 0;
		check_count = 0;
		tick(2);
		rst = 1'b0;
		tick(3);
		t_power_up();
		t_commands();
		t_sleep_refused();
		t_sleep_wake();
		t_forced_sleep();
		t_overload();
		t_forced_normal();
		end_of_test();
	end
endmodule
`default_nettype wire
